// >>> hw/idu_defines.svh
`ifndef IDU_DEFINES_SVH
`define IDU_DEFINES_SVH
// register byte addresses
`define IDU_AW 8
`define IDU_A_CTRL 8'h00
`define IDU_A_STATUS 8'h04
`define IDU_A_OPWORD 8'h08
`define IDU_A_EXTWORD 8'h0C
`define IDU_A_SRCOP 8'h10
`define IDU_A_CCR 8'h14
`define IDU_A_DREG_LO 8'h40
`define IDU_A_DREG_HI 8'h5C
// axi responses
`define IDU_RESP_OKAY 2'h0
`define IDU_RESP_DECERR 2'h3
// control and status bits
`define IDU_CTRL_START 0
`define IDU_ST_BUSY 0
`define IDU_ST_DONE 1
`define IDU_ST_TRAP 2
`define IDU_ST_ILLEGAL 3
`define IDU_ST_OVF 4
// opcode fields
`define IDU_OP_WORD_TOP 4'h8
`define IDU_OPM_SIGNED 3'h7
`define IDU_OPM_UNSIGNED 3'h3
`define IDU_OP_LONG 10'h131
`define IDU_EXT_SIGNED 11
`define IDU_EXT_SIZE 10
`define IDU_EXT_DA 15
// addressing modes
`define IDU_MODE_DN 3'h0
`define IDU_MODE_AN 3'h1
`define IDU_MODE_EXT 3'h7
`define IDU_EXT_IMM 3'h4
// divider
`define IDU_ITER 7'h40
`define IDU_LIM_W_POS 64'h0000_0000_0000_7FFF
`define IDU_LIM_W_NEG 64'h0000_0000_0000_8000
`define IDU_LIM_L_POS 64'h0000_0000_7FFF_FFFF
`define IDU_LIM_L_NEG 64'h0000_0000_8000_0000
`endif

// >>> hw/idu_pkg.sv
`default_nettype none
package idu_pkg;
  typedef enum logic [1:0] {IDU_IDLE, IDU_RUN, IDU_FIN} idu_state_t;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } idu_ccr_t;
  typedef struct packed {
    logic valid;
    logic long_f;
    logic signed_f;
    logic size64;
    logic [2:0] dq;
    logic [2:0] dr;
    logic src_dreg;
  } idu_op_t;
endpackage
`default_nettype wire

// >>> hw/idu_divide_unit.sv
// Summary of operation
// - negative flag follows quotient sign; kept on overflow or zero divide
// - zero flag set when quotient is zero; kept on overflow or zero divide
// - overflow flag set on overflow, cleared otherwise, kept on zero divide; carry cleared; extend kept
// - word form: top nibble 1000, reg 11-9, opmode 111 or 011, ea 5-0
// - word form register field picks destination, also the 32-bit dividend
// - source accepts data modes only; address register direct is illegal
// - mode 111 subfield: short, long, pc disp, pc indexed, immediate
// - word form overflows when quotient misses 16-bit range; unsigned here overflows above 7FFF
// - long forms overflow when quotient misses 32-bit range; unsigned here overflows above 7FFF_FFFF
// - long quotient register gives low dividend and takes the quotient
// - size bit picks 32-bit dividend or 64-bit register pair
// - remainder register gets remainder unless it names quotient register
// - with size one the remainder register gives upper dividend half
// - word form: quotient to low half, remainder to high half
// - first long form writes only the 32-bit quotient
// - 64/32 long form returns quotient and remainder
// - 32/32 remainder form returns quotient and remainder separately
// - zero divisor requests a trap, no result written
// - on overflow set overflow flag, leave destinations untouched
// - unsigned variants treat operands and results as unsigned
// - signed word remainder takes the dividend sign
// - signed variants use two's complement operands and results
`include "idu_defines.svh"
`default_nettype none
module idu_divide_unit
  import idu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [`IDU_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`IDU_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sequencer handshake
  output logic div_busy,
  output logic div_done,
  output logic div_trap
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [63:0] mag64(input logic [63:0] x,
                                        input logic s);
    return s ? (~x + 64'h1) : x;
  endfunction

  function automatic logic [31:0] mag32(input logic [31:0] x,
                                        input logic s);
    return s ? (~x + 32'h1) : x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [`IDU_AW-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire;
  logic wr_ctrl, wr_op, wr_ext, wr_src, wr_ccr, wr_dreg, wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;

  logic [15:0] opword_q, extword_q;
  logic [31:0] srcop_q;
  idu_ccr_t ccr_q;
  logic [31:0] dreg_q [8];
  logic [4:0] status_q;
  idu_state_t state_q;

  assign wr_fire = !awready_q && !wready_q && !bvalid_q;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_op = 1'b0;
    wr_ext = 1'b0;
    wr_src = 1'b0;
    wr_ccr = 1'b0;
    wr_dreg = 1'b0;
    if (awaddr_q == `IDU_A_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (awaddr_q == `IDU_A_OPWORD) begin
      wr_op = 1'b1;
    end else if (awaddr_q == `IDU_A_EXTWORD) begin
      wr_ext = 1'b1;
    end else if (awaddr_q == `IDU_A_SRCOP) begin
      wr_src = 1'b1;
    end else if (awaddr_q == `IDU_A_CCR) begin
      wr_ccr = 1'b1;
    end else if (awaddr_q >= `IDU_A_DREG_LO && awaddr_q <= `IDU_A_DREG_HI
                 && awaddr_q[1:0] == 2'h0) begin
      wr_dreg = 1'b1;
    end
    wr_hit = wr_ctrl | wr_op | wr_ext | wr_src | wr_ccr | wr_dreg |
             (awaddr_q == `IDU_A_STATUS);
  end

  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    if (s_axi_araddr == `IDU_A_CTRL) begin
      rd_val = 32'h0;
    end else if (s_axi_araddr == `IDU_A_STATUS) begin
      rd_val = {27'h0, status_q};
    end else if (s_axi_araddr == `IDU_A_OPWORD) begin
      rd_val = {16'h0, opword_q};
    end else if (s_axi_araddr == `IDU_A_EXTWORD) begin
      rd_val = {16'h0, extword_q};
    end else if (s_axi_araddr == `IDU_A_SRCOP) begin
      rd_val = srcop_q;
    end else if (s_axi_araddr == `IDU_A_CCR) begin
      rd_val = {27'h0, ccr_q};
    end else if (s_axi_araddr >= `IDU_A_DREG_LO &&
                 s_axi_araddr <= `IDU_A_DREG_HI &&
                 s_axi_araddr[1:0] == 2'h0) begin
      rd_val = dreg_q[s_axi_araddr[4:2]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // address and data may arrive in either order; each is held until both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `IDU_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (awready_q && s_axi_awvalid) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (wready_q && s_axi_wvalid) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `IDU_RESP_OKAY : `IDU_RESP_DECERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `IDU_RESP_OKAY;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `IDU_RESP_OKAY : `IDU_RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // instruction words and source operand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opword_q <= 16'h0;
      extword_q <= 16'h0;
      srcop_q <= 32'h0;
    end else if (wr_fire) begin
      if (wr_op) begin
        opword_q <= 16'(apply_strb({16'h0, opword_q}, wdata_q, wstrb_q));
      end
      if (wr_ext) begin
        extword_q <= 16'(apply_strb({16'h0, extword_q}, wdata_q, wstrb_q));
      end
      if (wr_src) begin
        srcop_q <= apply_strb(srcop_q, wdata_q, wstrb_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  idu_op_t dec;
  logic start;
  logic mode_ok;
  logic [2:0] ea_mode, ea_reg;

  assign start = wr_fire && wr_ctrl && wstrb_q[0] &&
                 wdata_q[`IDU_CTRL_START];
  assign ea_mode = opword_q[5:3];
  assign ea_reg = opword_q[2:0];

  always_comb begin
    // address register direct and unused mode 111 subcodes are illegal
    mode_ok = (ea_mode != `IDU_MODE_AN) &&
              !(ea_mode == `IDU_MODE_EXT && ea_reg > `IDU_EXT_IMM);
    dec = '0;
    dec.src_dreg = (ea_mode == `IDU_MODE_DN);
    if (opword_q[15:12] == `IDU_OP_WORD_TOP &&
        (opword_q[8:6] == `IDU_OPM_SIGNED ||
         opword_q[8:6] == `IDU_OPM_UNSIGNED)) begin
      dec.valid = mode_ok;
      dec.signed_f = opword_q[8:6] == `IDU_OPM_SIGNED;
      dec.dq = opword_q[11:9];
      dec.dr = opword_q[11:9];
    end else if (opword_q[15:6] == `IDU_OP_LONG) begin
      dec.valid = mode_ok && !extword_q[`IDU_EXT_DA];
      dec.long_f = 1'b1;
      dec.signed_f = extword_q[`IDU_EXT_SIGNED];
      dec.size64 = extword_q[`IDU_EXT_SIZE];
      dec.dq = extword_q[14:12];
      dec.dr = extword_q[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand preparation
  logic [31:0] src_val, dvs_raw, dq_val, dr_val;
  logic [63:0] dvd_raw;
  logic dvd_neg, dvs_neg;

  always_comb begin
    src_val = dec.src_dreg ? dreg_q[ea_reg] : srcop_q;
    dq_val = dreg_q[dec.dq];
    dr_val = dreg_q[dec.dr];
    // unsigned forms never sign-extend
    if (dec.long_f) begin
      dvs_raw = src_val;
    end else begin
      dvs_raw = {{16{dec.signed_f & src_val[15]}}, src_val[15:0]};
    end
    if (dec.long_f && dec.size64) begin
      dvd_raw = {dr_val, dq_val};
    end else begin
      dvd_raw = {{32{dec.signed_f & dq_val[31]}}, dq_val};
    end
    dvd_neg = dec.signed_f & dvd_raw[63];
    dvs_neg = dec.signed_f & dvs_raw[31];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and restoring divider, one quotient bit per cycle
  idu_op_t op_q;
  logic [6:0] cnt_q;
  logic [63:0] quo_q;
  logic [31:0] rem_q, dvs_q;
  logic qneg_q, rneg_q, busy_q, done_q, trap_q;
  logic [32:0] shifted;

  assign shifted = {rem_q, quo_q[63]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= IDU_IDLE;
      op_q <= '0;
      cnt_q <= 7'h0;
      quo_q <= 64'h0;
      rem_q <= 32'h0;
      dvs_q <= 32'h0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end else begin
      case (state_q)
        IDU_IDLE: begin
          if (start && dec.valid && dvs_raw != 32'h0) begin
            state_q <= IDU_RUN;
            op_q <= dec;
            cnt_q <= `IDU_ITER;
            quo_q <= mag64(dvd_raw, dvd_neg);
            rem_q <= 32'h0;
            dvs_q <= mag32(dvs_raw, dvs_neg);
            qneg_q <= dvd_neg ^ dvs_neg;
            rneg_q <= dvd_neg;
          end
        end
        IDU_RUN: begin
          if (shifted >= {1'b0, dvs_q}) begin
            rem_q <= 32'(shifted - {1'b0, dvs_q});
            quo_q <= {quo_q[62:0], 1'b1};
          end else begin
            rem_q <= shifted[31:0];
            quo_q <= {quo_q[62:0], 1'b0};
          end
          cnt_q <= cnt_q - 7'h1;
          if (cnt_q == 7'h1) begin
            state_q <= IDU_FIN;
          end
        end
        IDU_FIN: begin
          state_q <= IDU_IDLE;
        end
        default: begin
          state_q <= IDU_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result, overflow and completion
  logic [63:0] limit;
  logic ovf;
  logic [31:0] q_res, r_res;

  always_comb begin
    // unsigned forms share the signed positive range of the result
    if (!op_q.long_f) begin
      limit = (op_q.signed_f && qneg_q) ? `IDU_LIM_W_NEG : `IDU_LIM_W_POS;
    end else begin
      limit = (op_q.signed_f && qneg_q) ? `IDU_LIM_L_NEG : `IDU_LIM_L_POS;
    end
    ovf = quo_q > limit;
    q_res = mag32(quo_q[31:0], qneg_q);
    r_res = mag32(rem_q, rneg_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      trap_q <= 1'b0;
      status_q <= 5'h0;
    end else begin
      done_q <= 1'b0;
      trap_q <= 1'b0;
      if (state_q == IDU_IDLE && start) begin
        status_q <= 5'h0;
        if (!dec.valid) begin
          done_q <= 1'b1;
          status_q[`IDU_ST_DONE] <= 1'b1;
          status_q[`IDU_ST_ILLEGAL] <= 1'b1;
        end else if (dvs_raw == 32'h0) begin
          done_q <= 1'b1;
          trap_q <= 1'b1;
          status_q[`IDU_ST_DONE] <= 1'b1;
          status_q[`IDU_ST_TRAP] <= 1'b1;
        end else begin
          busy_q <= 1'b1;
          status_q[`IDU_ST_BUSY] <= 1'b1;
        end
      end else if (state_q == IDU_FIN) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        status_q[`IDU_ST_BUSY] <= 1'b0;
        status_q[`IDU_ST_DONE] <= 1'b1;
        status_q[`IDU_ST_OVF] <= ovf;
      end
    end
  end

  assign div_busy = busy_q;
  assign div_done = done_q;
  assign div_trap = trap_q;

  ////////////////////////////////////////////////////////////////////////////
  // data registers and condition codes; the unit's writeback wins over bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        dreg_q[i] <= 32'h0;
      end
    end else if (state_q == IDU_FIN) begin
      if (!ovf) begin
        if (!op_q.long_f) begin
          dreg_q[op_q.dq] <= {r_res[15:0], q_res[15:0]};
        end else begin
          dreg_q[op_q.dq] <= q_res;
          if (op_q.dr != op_q.dq) begin
            dreg_q[op_q.dr] <= r_res;
          end
        end
      end
    end else if (wr_fire && wr_dreg) begin
      dreg_q[awaddr_q[4:2]] <= apply_strb(dreg_q[awaddr_q[4:2]], wdata_q,
                                          wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ccr_q <= '0;
    end else if (state_q == IDU_FIN) begin
      ccr_q.c <= 1'b0;
      ccr_q.v <= ovf;
      if (!ovf) begin
        ccr_q.n <= op_q.long_f ? q_res[31] : q_res[15];
        ccr_q.z <= op_q.long_f ? (q_res == 32'h0) :
                                 (q_res[15:0] == 16'h0);
      end
    end else if (state_q == IDU_IDLE && start && dec.valid &&
                 dvs_raw == 32'h0) begin
      ccr_q.c <= 1'b0;
    end else if (wr_fire && wr_ccr && wstrb_q[0]) begin
      ccr_q <= wdata_q[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic ok_done;
  assign ok_done = done_q && !trap_q && !status_q[`IDU_ST_ILLEGAL] &&
                   !status_q[`IDU_ST_OVF];

  property p_carry_clear;
    @(posedge aclk) disable iff (!aresetn)
    (done_q && !status_q[`IDU_ST_ILLEGAL]) |-> !ccr_q.c;
  endproperty
  a_carry_clear: assert property (p_carry_clear)
    else $error("carry not cleared after divide");

  property p_extend_kept;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == IDU_FIN) |=> (ccr_q.x == $past(ccr_q.x));
  endproperty
  a_extend_kept: assert property (p_extend_kept)
    else $error("extend flag changed by divide");

  property p_ovf_nowrite;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == IDU_FIN && ovf) |=> ccr_q.v && done_q &&
      $stable(dreg_q[op_q.dq]) && $stable(dreg_q[op_q.dr]);
  endproperty
  a_ovf_nowrite: assert property (p_ovf_nowrite)
    else $error("destination changed on overflow");

  property p_zero_trap;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == IDU_IDLE && start && dec.valid && dvs_raw == 32'h0) |=>
      trap_q && done_q && state_q == IDU_IDLE ##1 !trap_q;
  endproperty
  a_zero_trap: assert property (p_zero_trap)
    else $error("zero divisor gave no single trap pulse");

  property p_neg_flag;
    @(posedge aclk) disable iff (!aresetn)
    ok_done |-> ccr_q.n == (op_q.long_f ? dreg_q[op_q.dq][31] :
                                          dreg_q[op_q.dq][15]);
  endproperty
  a_neg_flag: assert property (p_neg_flag)
    else $error("negative flag does not match quotient");

  property p_zero_flag;
    @(posedge aclk) disable iff (!aresetn)
    ok_done |-> ccr_q.z == (op_q.long_f ? dreg_q[op_q.dq] == 32'h0 :
                                          dreg_q[op_q.dq][15:0] == 16'h0);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag does not match quotient");

  property p_word_ovf;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == IDU_FIN && !op_q.long_f && op_q.signed_f && !qneg_q &&
     quo_q > `IDU_LIM_W_POS) |-> ovf;
  endproperty
  a_word_ovf: assert property (p_word_ovf)
    else $error("signed word overflow missed");

  property p_done_bound;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == IDU_IDLE && start && dec.valid && dvs_raw != 32'h0) |->
      ##66 done_q;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("divide did not finish in 66 cycles");

  property p_same_reg;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == IDU_FIN && op_q.long_f && !ovf && op_q.dr == op_q.dq) |=>
      dreg_q[op_q.dq] == $past(q_res);
  endproperty
  a_same_reg: assert property (p_same_reg)
    else $error("quotient lost when registers coincide");

  c_trap: cover property (@(posedge aclk) disable iff (!aresetn) trap_q);
  c_ovf: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == IDU_FIN && ovf);
  c_long_rem: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == IDU_FIN && !ovf && op_q.size64 && op_q.dr != op_q.dq);

endmodule
`default_nettype wire

// >>> bench/idu_axi_master.sv
`default_nettype none
module idu_axi_master (
  // clock
  input wire logic aclk,
  // write side
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read side
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  int hangs = 0;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // released payload is inverted so a stale value never looks fresh
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] st, output logic [1:0] rsp);
    logic b;
    b = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, st};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 500 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
    end
    rsp = s_axi_bresp;
    {s_axi_awaddr, s_axi_wdata, s_axi_bready} <= {~a, ~d, 1'b0};
    hangs += !b;
    // one idle edge so back-to-back calls never assign twice in a step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] rsp);
    logic r;
    r = 1'b0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 500 && !r; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      r = s_axi_rvalid;
    end
    {d, rsp} = {s_axi_rdata, s_axi_rresp};
    {s_axi_araddr, s_axi_rready} <= {~a, 1'b0};
    hangs += !r;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// >>> bench/integer_divide_unit_tb_top.sv
`default_nettype none
module integer_divide_unit_tb_top
  import idu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, div_busy, div_done, div_trap;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 32'h462D;
  int dones = 0;
  logic trap_seen = 1'b0;
  logic [31:0] d[8];
  // last three entries are illegal source modes
  logic [5:0] eas[14] = '{6'h03, 6'h32, 6'h13, 6'h1C, 6'h25, 6'h2E,
    6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3C, 6'h09, 6'h3D, 6'h3F};
  always #5 aclk = ~aclk;
  // done is a one-cycle pulse, so it is latched here rather than polled
  always @(posedge aclk) if (div_done) begin
    dones <= dones + 1;
    trap_seen <= div_trap;
  end
  idu_divide_unit i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .div_busy, .div_done, .div_trap);
  idu_axi_master i_mst (.aclk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    mismatches += i_mst.hangs;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] rs;
    i_mst.rd(a, v, rs);
    chk(v, e);
    chk(32'(rs), 32'(er));
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    i_mst.wr(a, v, 4'hF, rs);
    chk(32'(rs), 32'h0);
  endtask
  function automatic logic [31:0] sh();
    return $random(seed) >>> ($random(seed) & 31);
  endfunction
  //////////////////////////////////////////////////////////////////////
  task automatic op(input int lf, sg, s64, dq, dr, ea,
      input logic [31:0] src);
    logic [15:0] ow;
    logic [31:0] v, q, r;
    logic [63:0] un, uq, ur;
    longint sn, sq, sr;
    logic bad, ov;
    idu_ccr_t c;
    int n0;
    ow = lf[0] ? {10'h131, ea[5:0]} : {4'h8, dq[2:0],
      (sg[0] ? 3'h7 : 3'h3), ea[5:0]};
    c = idu_ccr_t'(5'(sh()));
    foreach (d[k]) w(8'h40 + 8'(4 * k), d[k]);
    w(8'h14, 32'(c));
    w(8'h08, 32'(ow));
    w(8'h0C, {17'h0, dq[2:0], sg[0], s64[0], 7'h0, dr[2:0]});
    w(8'h10, src);
    v = ea[5:3] == 0 ? d[ea[2:0]] : src;
    if (!lf[0]) v = sg[0] ? 32'($signed(v[15:0])) : 32'(v[15:0]);
    bad = ea[5:3] == 1 || (ea[5:3] == 7 && ea[2:0] > 4);
    un = lf[0] && s64[0] ? {d[dr], d[dq]} : 64'(d[dq]);
    sn = lf[0] && s64[0] ? $signed({d[dr], d[dq]})
                         : longint'($signed(d[dq]));
    if (v != 0) begin
      sq = sn / $signed(v);
      sr = sn % $signed(v);
      uq = un / v;
      ur = un % v;
    end
    q = sg[0] ? 32'(sq) : uq[31:0];
    r = sg[0] ? 32'(sr) : ur[31:0];
    ov = sg[0] ? sq != (lf[0] ? longint'($signed(q))
                              : longint'($signed(q[15:0])))
               : (uq >> (lf[0] ? 31 : 15)) != 0;
    n0 = dones;
    w(8'h00, 32'h1);
    chk(32'(div_busy), 32'(!bad && v != 0));
    for (int i = 0; i < 100 && dones == n0; i++) @(posedge aclk);
    if (dones == n0) begin
      mismatches++;
      summarize();
    end
    chk(32'(trap_seen), 32'(!bad && v == 0));
    if (!bad && v == 0) c.c = 1'b0;
    else if (!bad && ov) {c.v, c.c} = 2'h2;
    else if (!bad) begin
      {c.n, c.z, c.v, c.c} = {(lf[0] ? q[31] : q[15]),
        ((lf[0] ? q : 32'(q[15:0])) == 0), 2'h0};
      if (!lf[0]) d[dq] = {r[15:0], q[15:0]};
      if (lf[0] && dr != dq) d[dr] = r;
      if (lf[0]) d[dq] = q;
    end
    rchk(8'h04, {27'h0, (!bad && v != 0 && ov), bad,
      (!bad && v == 0), 2'h2}, 2'h0);
    rchk(8'h14, 32'(c), 2'h0);
    foreach (d[k]) rchk(8'h40 + 8'(4 * k), d[k], 2'h0);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] rs;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(8'h14, 32'h0, 2'h0);
    rchk(8'h18, 32'h0, 2'h3);
    i_mst.wr(8'h40, 32'hA5A5_1234, 4'h3, rs);
    chk(32'(rs), 32'h0);
    rchk(8'h40, 32'h0000_1234, 2'h0);
    i_mst.wr(8'h18, 32'h1, 4'hF, rs);
    chk(32'(rs), 32'h3);
    foreach (eas[i]) begin
      foreach (d[k]) d[k] = sh();
      op(i, i >> 1, i >> 2, i & 7, (i + 3) & 7, eas[i], sh() >> 16);
    end
    repeat (40) begin
      foreach (d[k]) d[k] = sh();
      op($random(seed), $random(seed), $random(seed), $random(seed) & 7,
        $random(seed) & 7, eas[($random(seed) & 15) % 11], sh());
    end
    d = '{default: 32'h0};
    d[2] = 32'h0001_0000;
    op(0, 0, 0, 2, 0, 6'h3C, 32'h1);
    d[2] = 32'h0000_8000;
    d[3] = 32'h1;
    op(0, 1, 0, 2, 0, 6'h3C, 32'h1);
    op(1, 1, 1, 2, 3, 6'h3C, 32'h1);
    d[4] = 32'h8000_0000;
    op(1, 1, 0, 4, 4, 6'h3C, 32'hFFFF_FFFF);
    op(1, 0, 0, 4, 5, 6'h3C, 32'h0);
    op(0, 1, 0, 4, 0, 6'h00, 32'h7);
    d[6] = 32'hFFFF_FFF9;
    op(0, 1, 0, 6, 0, 6'h3C, 32'h2);
    op(1, 0, 0, 6, 7, 6'h3C, 32'h2);
    op(1, 1, 0, 6, 6, 6'h3C, 32'h2);
    op(1, 1, 1, 2, 3, 6'h3C, 32'h10);
    summarize();
  end
endmodule
`default_nettype wire
